// >>> src/sync_rx_regs.svh
`ifndef SYNC_RX_REGS_SVH
`define SYNC_RX_REGS_SVH
// ********************************
// register indexes, byte addr = 4x
// ********************************
`define IDX_IRQ_FLAGS 8'h16
`define IDX_IRQ_EN    8'h17
`define IDX_RX_STAT   8'h18
`define IDX_BAUD      8'h19
`define IDX_RX_DATA   8'h1a
`define IDX_PORT_CFG  8'h1b
// ********************************
// field positions
// ********************************
`define BIT_RX_FLAG   0
`define BIT_TX_FLAG   1
`define BIT_RX_IE     0
`define BIT_PORT_EN   7
`define BIT_NINE      6
`define BIT_SINGLE    5
`define BIT_CONT      4
`define BIT_FRAME     2
`define BIT_OVERRUN   1
`define BIT_NINTH     0
`define BIT_CLK_MSTR  7
`define BIT_SYNC_MODE 4
// ********************************
// reset values
// ********************************
`define RST_IRQ_FLAGS 8'h02
`define RST_IRQ_EN    8'h00
`define RST_RX_STAT   8'h00
`define RST_BAUD      8'h00
`define RST_PORT_CFG  8'h00
`endif

// >>> src/sync_rx_pkg.sv
package sync_rx_pkg;
  // ********************************
  // receive engine states
  // ********************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HIGH = 3'b010,
    ST_LOW  = 3'b100
  } rx_state_t;

  // one queued word with its status
  typedef struct packed {
    logic       frame_err;
    logic       ninth;
    logic [7:0] data;
  } rx_word_t;

  // software controls
  typedef struct packed {
    logic       port_en;
    logic       nine_bit_mode;
    logic       single_en;
    logic       cont_en;
    logic       sync_mode;
    logic       clk_master;
    logic [7:0] irq_en;
    logic [7:0] baud;
  } rx_ctl_t;
endpackage : sync_rx_pkg

// >>> src/rx_buf2.sv
`timescale 1ns/1ps
`default_nettype none
module rx_buf2 #(
  parameter int W     = 10,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         flush,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
  } buf_state_t;

  buf_state_t q;
  buf_state_t d;
  logic       push;
  logic       pop;

  function automatic logic [AW-1:0] wrap(input logic [AW-1:0] p);
    wrap = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : wrap

  assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = in_data;
      d.wr        = wrap(q.wr);
    end
    if (pop) begin
      d.rd = wrap(q.rd);
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // flush drops entries, storage keeps stale words
    if (flush) begin
      d.wr  = '0;
      d.rd  = '0;
      d.cnt = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : rx_buf2
`default_nettype wire

// >>> src/sync_master_receiver.sv
// Function
// - reception starts when software sets single or continuous enable with port enabled in sync clock-master mode
// - data pin is sampled at each falling edge of the serial clock
// - single enable alone takes exactly one word, then stops
// - continuous enable keeps receiving until software clears it
// - with both enables set, continuous behaviour applies
// - after the last bit the word moves into the fifo if it has room
// - a fifo load sets rx flag; interrupt only while enable bit set
// - rx flag is read-only and clears when fifo is read empty
// - fifo holds two words while a third shifts in
// - third word finishing into a full fifo sets overrun and is lost
// - overrun clears only by clearing continuous enable
// - while overrun is set no word enters the fifo
// - ninth bit is queued with its data byte
// - reading data loads ninth and framing bits of the next word
// - clearing both enables or port enable resets receive logic
`timescale 1ns/1ps
`default_nettype none
`include "sync_rx_regs.svh"
module sync_master_receiver #(
  parameter int SYNC_STAGES = 2
) (
  // system
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // serial link
  output logic             SCK_O,
  output logic             SCK_OE,
  input  wire logic        DT_I,
  output logic             DT_O,
  output logic             DT_OE,
  // interrupt
  output logic             RX_IRQ
);
  // ********************************
  // state
  // ********************************
  typedef struct packed {
    sync_rx_pkg::rx_ctl_t   ctl;
    sync_rx_pkg::rx_state_t st;
    logic [7:0]             baud_cnt;
    logic [3:0]             bit_cnt;
    logic [8:0]             shreg;
    logic                   overrun;
    logic [SYNC_STAGES-1:0] dt_sync;
    logic                   dph_valid;
    logic                   dph_write;
    logic                   dph_wait;
    logic [5:0]             dph_sel;
    logic [31:0]            rdata;
  } core_t;

  core_t                 q;
  core_t                 d;
  sync_rx_pkg::rx_word_t in_word;
  sync_rx_pkg::rx_word_t head;
  logic                  buf_in_valid;
  logic                  buf_in_ready;
  logic                  buf_out_valid;
  logic                  buf_pop;
  logic                  buf_flush;
  logic                  word_done;
  logic                  fall;
  logic                  addr_ok;
  logic                  running;
  logic [8:0]            sh_next;

  // one-hot select: flags, enables, status, baud, data, cfg
  function automatic logic [5:0] decode(input logic [31:0] a);
    decode = '0;
    if (a[31:10] == '0) begin
      decode[0] = (a[9:2] == `IDX_IRQ_FLAGS);
      decode[1] = (a[9:2] == `IDX_IRQ_EN);
      decode[2] = (a[9:2] == `IDX_RX_STAT);
      decode[3] = (a[9:2] == `IDX_BAUD);
      decode[4] = (a[9:2] == `IDX_RX_DATA);
      decode[5] = (a[9:2] == `IDX_PORT_CFG);
    end
  endfunction : decode

  // ********************************
  // receive fifo
  // ********************************
  rx_buf2 #(
    .W     ($bits(sync_rx_pkg::rx_word_t)),
    .DEPTH (2)
  ) u_fifo (
    .clk       (CLK_SYS),
    .rst       (SYS_RST),
    .flush     (buf_flush),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (in_word),
    .out_valid (buf_out_valid),
    .out_ready (buf_pop),
    .out_data  (head)
  );

  // ********************************
  // outputs
  // ********************************
  assign HRDATA    = q.rdata;
  assign HRESP     = 1'b0;
  // reads take one wait so a just-written register reads back fresh
  assign HREADYOUT = !(q.dph_valid && !q.dph_write && q.dph_wait);
  assign SCK_O     = (q.st == sync_rx_pkg::ST_HIGH);
  assign SCK_OE    = q.ctl.port_en && q.ctl.sync_mode && q.ctl.clk_master;
  assign DT_O      = 1'b0;
  assign DT_OE     = 1'b0;
  assign RX_IRQ    = buf_out_valid && q.ctl.irq_en[`BIT_RX_IE];
  // only port-off flushes; clearing both enables keeps queued words
  assign buf_flush = !q.ctl.port_en;
  assign addr_ok   = HSEL && HREADY && HTRANS[1];
  assign running   = q.ctl.port_en && q.ctl.sync_mode && q.ctl.clk_master
                     && (q.ctl.single_en || q.ctl.cont_en);
  assign fall      = (q.st == sync_rx_pkg::ST_HIGH) && (q.baud_cnt == q.ctl.baud);
  assign sh_next   = {q.dt_sync[SYNC_STAGES-1], q.shreg[8:1]};
  assign word_done = fall && running
                     && (q.bit_cnt == (q.ctl.nine_bit_mode ? 4'h8 : 4'h7));
  assign buf_in_valid = word_done && !q.overrun;
  assign buf_pop   = q.dph_valid && !q.dph_write && q.dph_wait && q.dph_sel[4];

  always_comb begin
    in_word           = '0;
    in_word.data      = q.ctl.nine_bit_mode ? sh_next[7:0] : sh_next[8:1];
    in_word.ninth     = q.ctl.nine_bit_mode && sh_next[8];
    in_word.frame_err = 1'b0;
  end

  // ********************************
  // next state
  // ********************************
  always_comb begin
    d         = q;
    d.dt_sync = {q.dt_sync[SYNC_STAGES-2:0], DT_I};

    // serial engine
    if (!running) begin
      // back to the power-up state so a re-enable starts clean
      d.st       = sync_rx_pkg::ST_IDLE;
      d.baud_cnt = '0;
      d.bit_cnt  = '0;
      d.shreg    = '0;
    end else begin
      unique case (q.st)
        sync_rx_pkg::ST_IDLE: begin
          d.st       = sync_rx_pkg::ST_HIGH;
          d.baud_cnt = '0;
        end
        sync_rx_pkg::ST_HIGH: begin
          d.baud_cnt = q.baud_cnt + 8'h01;
          if (fall) begin
            d.st       = sync_rx_pkg::ST_LOW;
            d.baud_cnt = '0;
            d.shreg    = sh_next;
            d.bit_cnt  = word_done ? 4'h0 : q.bit_cnt + 4'h1;
          end
        end
        sync_rx_pkg::ST_LOW: begin
          d.baud_cnt = q.baud_cnt + 8'h01;
          if (q.baud_cnt == q.ctl.baud) begin
            d.st       = sync_rx_pkg::ST_HIGH;
            d.baud_cnt = '0;
          end
        end
      endcase
    end

    // single word done: drop single enable unless continuous is on
    if (word_done && !q.ctl.cont_en) begin
      d.ctl.single_en = 1'b0;
    end

    // overrun: cleared by continuous enable low, set wins
    // kept sticky so software still sees a lost word after draining the fifo
    if (!q.ctl.cont_en) begin
      d.overrun = 1'b0;
    end
    if (word_done && !q.overrun && !buf_in_ready) begin
      d.overrun = 1'b1;
    end

    // bus write data phase
    if (q.dph_valid && q.dph_write) begin
      if (q.dph_sel[1]) begin
        d.ctl.irq_en = HWDATA[7:0];
      end
      if (q.dph_sel[2]) begin
        d.ctl.port_en       = HWDATA[`BIT_PORT_EN];
        d.ctl.nine_bit_mode = HWDATA[`BIT_NINE];
        d.ctl.single_en     = HWDATA[`BIT_SINGLE];
        d.ctl.cont_en       = HWDATA[`BIT_CONT];
      end
      if (q.dph_sel[3]) begin
        d.ctl.baud = HWDATA[7:0];
      end
      if (q.dph_sel[5]) begin
        d.ctl.clk_master = HWDATA[`BIT_CLK_MSTR];
        d.ctl.sync_mode  = HWDATA[`BIT_SYNC_MODE];
      end
    end

    // bus read: data captured in the wait cycle
    if (q.dph_valid && !q.dph_write && q.dph_wait) begin
      d.rdata = '0;
      if (q.dph_sel[0]) begin
        d.rdata[7:0]          = `RST_IRQ_FLAGS;
        d.rdata[`BIT_RX_FLAG] = buf_out_valid;
      end
      if (q.dph_sel[1]) begin
        d.rdata[7:0] = q.ctl.irq_en;
      end
      if (q.dph_sel[2]) begin
        d.rdata[`BIT_PORT_EN] = q.ctl.port_en;
        d.rdata[`BIT_NINE]    = q.ctl.nine_bit_mode;
        d.rdata[`BIT_SINGLE]  = q.ctl.single_en;
        d.rdata[`BIT_CONT]    = q.ctl.cont_en;
        d.rdata[`BIT_FRAME]   = buf_out_valid && head.frame_err;
        d.rdata[`BIT_OVERRUN] = q.overrun;
        d.rdata[`BIT_NINTH]   = buf_out_valid && head.ninth;
      end
      if (q.dph_sel[3]) begin
        d.rdata[7:0] = q.ctl.baud;
      end
      if (q.dph_sel[4]) begin
        d.rdata[7:0] = buf_out_valid ? head.data : 8'h00;
      end
      if (q.dph_sel[5]) begin
        d.rdata[`BIT_CLK_MSTR]  = q.ctl.clk_master;
        d.rdata[`BIT_SYNC_MODE] = q.ctl.sync_mode;
      end
    end

    // address phase
    if (addr_ok) begin
      d.dph_valid = 1'b1;
      d.dph_write = HWRITE;
      d.dph_wait  = !HWRITE;
      d.dph_sel   = decode(HADDR);
    end else begin
      d.dph_valid = 1'b0;
      d.dph_wait  = 1'b0;
    end
  end

  // ********************************
  // registers
  // ********************************
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      q     <= '0;
      q.st  <= sync_rx_pkg::ST_IDLE;
      q.ctl <= '0;
    end else begin
      q <= d;
    end
  end

  // ********************************
  // checks
  // ********************************
  // one clock domain, so clock and reset are given once here
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);

  logic [2:0] pushes;
  assign pushes = {2'b00, buf_in_valid && buf_in_ready};

  clk_idle_a: assert property (!running |=> !SCK_O)
    else $error("serial clock high while not receiving");
  single_stop_a: assert property (word_done && !q.ctl.cont_en && !(q.dph_valid && q.dph_write)
                                  |=> !q.ctl.single_en && !SCK_O)
    else $error("single reception did not stop");
  // a software clear of the enables may stop the clock early
  cont_keep_a: assert property (word_done && q.ctl.cont_en && !(q.dph_valid && q.dph_write)
                                |=> q.ctl.cont_en ##[1:300] (SCK_O || !running))
    else $error("continuous reception stopped");
  load_flag_a: assert property (word_done && !q.overrun && buf_in_ready
                                |=> buf_out_valid)
    else $error("finished word not loaded");
  irq_gate_a: assert property ($rose(RX_IRQ) |-> q.ctl.irq_en[0] && buf_out_valid)
    else $error("interrupt without flag and enable");
  overrun_set_a: assert property (word_done && !q.overrun && !buf_in_ready && q.ctl.cont_en && !buf_pop
                                  |=> q.overrun && $stable(head))
    else $error("overrun not flagged");
  overrun_hold_a: assert property (q.overrun && q.ctl.cont_en |=> q.overrun)
    else $error("overrun cleared early");
  overrun_block_a: assert property (q.overrun |-> pushes == 3'h0)
    else $error("fifo load during overrun");
  port_off_a: assert property (!q.ctl.port_en |=> q.st == sync_rx_pkg::ST_IDLE
                               && q.bit_cnt == 4'h0 && !buf_out_valid)
    else $error("port disable did not reset receiver");
  fall_sample_a: assert property (fall && running
                                  |=> q.shreg[8] == $past(q.dt_sync[SYNC_STAGES-1]))
    else $error("bit not sampled at falling edge");
  start_clk_a: assert property (running && q.st == sync_rx_pkg::ST_IDLE |=> SCK_O)
    else $error("serial clock did not start");
  both_cont_a: assert property (word_done && q.ctl.single_en && q.ctl.cont_en
                                && !(q.dph_valid && q.dph_write) |=> q.ctl.single_en && q.ctl.cont_en)
    else $error("both enables did not stay continuous");
  irq_load_a: assert property (buf_in_valid && buf_in_ready && q.ctl.irq_en[`BIT_RX_IE]
                               && !(q.dph_valid && q.dph_write) |=> RX_IRQ)
    else $error("loaded word raised no interrupt");
  fifo_two_a: assert property (buf_in_valid && buf_in_ready && buf_out_valid && !buf_pop
                               |=> buf_out_valid && !buf_in_ready)
    else $error("fifo did not hold two words");
  // the stall must show at the fifo itself, not only at its write gate
  overrun_stall_a: assert property (q.overrun && !buf_pop && !buf_flush |=> $stable(buf_out_valid))
    else $error("fifo changed while overrun set");
  ninth_queue_a: assert property (buf_in_valid && buf_in_ready && !buf_out_valid
                                  |=> head.ninth == $past(q.ctl.nine_bit_mode && q.dt_sync[SYNC_STAGES-1]))
    else $error("ninth bit not queued with its byte");
  sck_half_a: assert property (running && q.st == sync_rx_pkg::ST_HIGH && q.baud_cnt != q.ctl.baud
                               |=> SCK_O && q.baud_cnt == $past(q.baud_cnt) + 8'h01)
    else $error("serial clock half period too short");
  idle_reset_a: assert property (!running |=> q.bit_cnt == 4'h0 && q.baud_cnt == 8'h00)
    else $error("receive counters not reset when idle");
  overrun_lost_a: assert property (word_done && !buf_in_ready && !buf_pop |=> !buf_in_ready)
    else $error("word entered a full fifo");

  // ********************************
  // coverage
  // ********************************
  word_in_c: cover property (word_done && buf_in_ready);
  full_c: cover property (word_done && !buf_in_ready);
  pop_c: cover property (buf_pop ##1 buf_out_valid);
  single_c: cover property (word_done && !q.ctl.cont_en);
  ovr_c: cover property (q.overrun && buf_pop);
endmodule : sync_master_receiver
`default_nettype wire

// >>> dv/sync_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// synchronous slave on the data line
// ********************************
module sync_slave_model (
  // link
  input  wire logic       sck,
  output logic            dt,
  // control from the bench
  input  wire logic       restart,
  input  wire logic [8:0] base,
  input  wire logic       nine
);
  int         bit_pos;
  logic [8:0] word;

  initial dt = 1'b0;

  // on restart the line flips to the inverse of its last bit until the first rising clock
  always @(posedge restart) begin
    bit_pos = 0;
    word    = base;
    dt      = ~dt;
  end

  // launch on the rising clock so the falling sample sees a settled bit
  always @(posedge sck) begin
    dt = word[bit_pos];
    bit_pos++;
    if (bit_pos == (nine ? 9 : 8)) begin
      bit_pos = 0;
      word    = word + 9'h001;
    end
  end
endmodule : sync_slave_model
`default_nettype wire

// >>> dv/sync_master_receiver_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sync_master_receiver_tb;
  // ********************************
  // byte addresses, index times four
  // ********************************
  localparam logic [31:0] A_FLAGS = 32'h58;
  localparam logic [31:0] A_IE    = 32'h5c;
  localparam logic [31:0] A_STAT  = 32'h60;
  localparam logic [31:0] A_BAUD  = 32'h64;
  localparam logic [31:0] A_DATA  = 32'h68;
  localparam logic [31:0] A_CFG   = 32'h6c;
  localparam logic [31:0] A_NONE  = 32'h70;

  logic        CLK_SYS, SYS_RST, HSEL, HWRITE, HREADYOUT, HRESP;
  logic [31:0] HADDR, HWDATA, HRDATA;
  logic [1:0]  HTRANS;
  logic        SCK_O, SCK_OE, DT_I, DT_O, DT_OE, RX_IRQ, restart, nine;
  logic [8:0]  base;
  int          n_errors, n_tests, cycles;

  sync_master_receiver #(.SYNC_STAGES(2)) sync_master_receiver_i (
    .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SCK_O(SCK_O), .SCK_OE(SCK_OE), .DT_I(DT_I),
    .DT_O(DT_O), .DT_OE(DT_OE), .RX_IRQ(RX_IRQ));

  sync_slave_model sync_slave_model_i (
    .sck(SCK_O), .dt(DT_I), .restart(restart), .base(base), .nine(nine));

  initial CLK_SYS = 1'b0;
  always #4 CLK_SYS = ~CLK_SYS;

  // hang guard, well above the few thousand cycles the tests need
  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      report_and_stop();
    end
  end

  // ********************************
  // shared tasks
  // ********************************
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge CLK_SYS);
    HSEL   <= 1'b1;
    HTRANS <= 2'b10;
    HWRITE <= wr;
    HADDR  <= addr;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    HSEL   <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
    chk("hresp", 32'h0, {31'h0, HRESP});
  endtask : bus

  task automatic wr(input logic [31:0] addr, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b1, addr, d, t);
  endtask : wr

  task automatic rdc(input string name, input logic [31:0] addr, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, addr, 32'h0, v);
    chk(name, exp, v);
  endtask : rdc

  task automatic poll(input logic [31:0] addr, input logic [31:0] mask);
    logic [31:0] v;
    v = 32'h0;
    while ((v & mask) == 32'h0) bus(1'b0, addr, 32'h0, v);
  endtask : poll

  task automatic sck_wait(input logic v);
    while (SCK_O !== v) @(posedge CLK_SYS);
  endtask : sck_wait

  task automatic restart_model(input logic [8:0] b, input logic n);
    base    <= b;
    nine    <= n;
    restart <= 1'b1;
    @(posedge CLK_SYS);
    restart <= 1'b0;
  endtask : restart_model

  task automatic single_word(input logic [8:0] b);
    int hi;
    restart_model(b, 1'b0);
    wr(A_STAT, 32'ha0);
    sck_wait(1'b1);
    sck_wait(1'b0);
    sck_wait(1'b1);
    hi = 0;
    while (SCK_O === 1'b1) begin
      @(posedge CLK_SYS);
      hi++;
    end
    chk("sck_high", 32'd10, 32'(hi));
    poll(A_FLAGS, 32'h1);
    chk("irq_on", 32'h1, {31'h0, RX_IRQ});
    rdc("stat_single", A_STAT, 32'h80);
    rdc("data_single", A_DATA, {24'h0, b[7:0]});
    rdc("flags_empty", A_FLAGS, 32'h02);
    chk("irq_off", 32'h0, {31'h0, RX_IRQ});
    repeat (200) @(posedge CLK_SYS);
    rdc("flags_one", A_FLAGS, 32'h02);
    chk("sck_idle", 32'h0, {31'h0, SCK_O});
  endtask : single_word

  // ********************************
  // main sequence
  // ********************************
  initial begin
    {HSEL, HWRITE, HADDR, HWDATA, HTRANS, restart, nine, base} = '0;
    SYS_RST = 1'b1;
    repeat (10) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    rdc("flags_rst", A_FLAGS, 32'h02);
    rdc("ie_rst", A_IE, 32'h00);
    rdc("stat_rst", A_STAT, 32'h00);
    rdc("baud_rst", A_BAUD, 32'h00);
    rdc("cfg_rst", A_CFG, 32'h00);
    rdc("data_rst", A_DATA, 32'h00);
    wr(A_IE, 32'hff);
    rdc("ie_rw", A_IE, 32'hff);
    wr(A_FLAGS, 32'hff);
    rdc("flags_ro", A_FLAGS, 32'h02);
    wr(A_NONE, 32'hff);
    rdc("unmapped", A_NONE, 32'h00);
    chk("dt_idle", 32'h0, {30'h0, DT_O, DT_OE});
    $display("test registers done");
    // divisor, mode bits, port enable, then the interrupt enable
    wr(A_BAUD, 32'h09);
    wr(A_CFG, 32'h90);
    wr(A_STAT, 32'h80);
    wr(A_IE, 32'h01);
    rdc("baud_rw", A_BAUD, 32'h09);
    chk("sck_oe_on", 32'h1, {31'h0, SCK_OE});
    single_word(9'h0a5);
    $display("test single done");
    // nine-bit continuous, fifo left full until overrun
    restart_model(9'h0ff, 1'b1);
    wr(A_STAT, 32'hd0);
    poll(A_STAT, 32'h02);
    chk("irq_full", 32'h1, {31'h0, RX_IRQ});
    wr(A_IE, 32'h00);
    @(posedge CLK_SYS);
    chk("irq_masked", 32'h0, {31'h0, RX_IRQ});
    wr(A_IE, 32'h01);
    rdc("stat_w0", A_STAT, 32'hd2);
    rdc("data_w0", A_DATA, 32'hff);
    rdc("stat_w1", A_STAT, 32'hd3);
    rdc("data_w1", A_DATA, 32'h00);
    rdc("flags_drain", A_FLAGS, 32'h02);
    repeat (400) @(posedge CLK_SYS);
    rdc("flags_block", A_FLAGS, 32'h02);
    wr(A_STAT, 32'hc0);
    rdc("ovr_clear", A_STAT, 32'hc0);
    $display("test overrun done");
    // both enables: continuous wins, then port off and re-enable
    restart_model(9'h055, 1'b0);
    wr(A_STAT, 32'hb0);
    poll(A_STAT, 32'h02);
    rdc("data_both", A_DATA, 32'h55);
    wr(A_STAT, 32'h00);
    rdc("flags_flush", A_FLAGS, 32'h02);
    rdc("stat_off", A_STAT, 32'h00);
    chk("sck_oe_off", 32'h0, {31'h0, SCK_OE});
    wr(A_STAT, 32'h80);
    single_word(9'h03c);
    $display("test terminate done");
    report_and_stop();
  end
endmodule : sync_master_receiver_tb
`default_nettype wire
